// ===== rtl/lac_defines.vh
// Purpose: constants for the latch acknowledge controller
// Assumes: 100 MHz system clock
// Notes: times in ms, cycle counts derived from them; off delay given in cycles
`ifndef LAC_DEFINES_VH
`define LAC_DEFINES_VH
`define LAC_CLK_HZ 100000000
`define LAC_LONG_PRESS_MS 1000
`define LAC_LAMP_PHASE_MS 1000
`define LAC_MS_TO_CYC(ms) (((ms) * (`LAC_CLK_HZ / 1000)))
`define LAC_LONG_PRESS_CYC `LAC_MS_TO_CYC(`LAC_LONG_PRESS_MS)
`define LAC_LAMP_PHASE_CYC `LAC_MS_TO_CYC(`LAC_LAMP_PHASE_MS)
`define LAC_OFF_DLY_CYC 100
// Long-press scope setting codes
`define LAC_SCOPE_NOTHING 3'h0
`define LAC_SCOPE_LEDS_NO_PW 3'h1
`define LAC_SCOPE_LEDS 3'h2
`define LAC_SCOPE_LEDS_AND_OUTPUTS 3'h3
`define LAC_SCOPE_EVERYTHING 3'h4
`define LAC_SCOPE_RST 3'h1
// Register map (word addresses)
`define LAC_ADDR_CTRL 4'h0
`define LAC_ADDR_CMD 4'h1
`define LAC_ADDR_STATUS 4'h2
`define LAC_ADDR_SG_ACK 4'h3
`define LAC_ADDR_LED_LAT 4'h4
`define LAC_ADDR_OUT_LAT 4'h5
`define LAC_ADDR_SCADA_LAT 4'h6
`define LAC_ADDR_TRIP_LAT 4'h7
// CTRL fields
`define LAC_CTRL_SCOPE_LSB 0
`define LAC_CTRL_REMOTE_EN 3
`define LAC_CTRL_EDIT_MODE 4
`define LAC_CTRL_PW_EMPTY 5
`define LAC_CTRL_RST 8'h09
// CMD bits
`define LAC_CMD_LED 0
`define LAC_CMD_OUT 1
`define LAC_CMD_SCADA 2
`define LAC_CMD_ALL 3
`define LAC_CMD_CONFIRM 4
`define LAC_CMD_PW_OK 5
`define LAC_CMD_CANCEL 6
`endif

// ===== rtl/lac_key_timer.v
// Purpose: classify clear-key presses as short or long
// Assumes: key input already debounced, synchronous
// Notes: long action fires once per press
`timescale 1ns/1ps
`include "lac_defines.vh"
module lac_key_timer #(
  parameter LONG_CYC = `LAC_LONG_PRESS_CYC,
  parameter CW = 27
)(
  input wire i_clk,
  input wire i_rst_n,
  input wire i_key,
  input wire i_block,
  output reg o_short,
  output reg o_long
);
  reg [CW-1:0] cnt_r;
  reg key_d_r;
  reg fired_r;
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= {CW{1'b0}};
      key_d_r <= 1'b0;
      fired_r <= 1'b0;
      o_short <= 1'b0;
      o_long <= 1'b0;
    end
    else
    begin
      key_d_r <= i_key & ~i_block;
      o_short <= 1'b0;
      o_long <= 1'b0;
      if (i_key & ~i_block)
      begin
        if (!fired_r && cnt_r == LONG_CYC[CW-1:0] - 1'b1)
        begin
          o_long <= 1'b1;
          fired_r <= 1'b1;
        end
        if (!fired_r)
          cnt_r <= cnt_r + 1'b1;
      end
      else
      begin
        if (key_d_r && !fired_r && !i_block)
          o_short <= 1'b1;
        cnt_r <= {CW{1'b0}};
        fired_r <= 1'b0;
      end
    end
  end
endmodule // lac_key_timer

// ===== rtl/lac_lamp_test.v
// Purpose: red then green LED lamp test
// Assumes: start is a one-cycle pulse
// Notes: a new start restarts the sequence
`timescale 1ns/1ps
`include "lac_defines.vh"
module lac_lamp_test #(
  parameter PHASE_CYC = `LAC_LAMP_PHASE_CYC,
  parameter CW = 27
)(
  input wire i_clk,
  input wire i_rst_n,
  input wire i_start,
  output reg o_red,
  output reg o_green
);
  reg [CW-1:0] cnt_r;
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= {CW{1'b0}};
      o_red <= 1'b0;
      o_green <= 1'b0;
    end
    else if (i_start)
    begin
      cnt_r <= {CW{1'b0}};
      o_red <= 1'b1;
      o_green <= 1'b0;
    end
    else if (o_red | o_green)
    begin
      if (cnt_r == PHASE_CYC[CW-1:0] - 1'b1)
      begin
        cnt_r <= {CW{1'b0}};
        o_green <= o_red;
        o_red <= 1'b0;
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // lac_lamp_test

// ===== rtl/lac_ctrl.v
// Purpose: acknowledge controller for latched LEDs, outputs, SCADA, trips
// Assumes: synchronous inputs, one 100 MHz clock
// Notes: latches are set here from source signals, cleared by acknowledge
// Summary of operation
// - Collective SCADA command clears all latched SCADA signals.
// - Switchgear acknowledge clears only that switchgear's latched trip.
// - Combined command clears LEDs, outputs, SCADA and trips together.
// - Clear key ignored while panel is in parameter-editing mode.
// - Collective commands still work in parameter-editing mode.
// - Short press opens selection; clearing waits for confirm softkey.
// - One-second hold acknowledges configured scope without the selection step.
// - Nothing scope: long press does nothing.
// - Scope resets to LEDs without password.
// - LEDs scope clears LEDs after password.
// - LEDs-and-outputs scope clears LEDs and outputs after password.
// - Everything scope clears all four categories after password.
// - Every LED acknowledge starts red then green lamp test.
// - Paths other than nothing and passwordless LEDs may need password.
// - Empty first-level password skips prompt for outputs, SCADA, trips.
// - Latch clears only if its source signal is inactive.
// - Remote disabled: only panel acknowledges take effect.
// - Output latch releases only after its switch-off delay elapses.
`timescale 1ns/1ps
`include "lac_defines.vh"
module lac_ctrl #(
  parameter N_LED = 14,
  parameter N_OUT = 8,
  parameter N_SCADA = 16,
  parameter N_SG = 4,
  parameter LONG_CYC = `LAC_LONG_PRESS_CYC,
  parameter LAMP_CYC = `LAC_LAMP_PHASE_CYC,
  parameter OFF_DLY_CYC = `LAC_OFF_DLY_CYC,
  parameter CW = 27
)(
  input wire i_clk,
  input wire i_rst_n,
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_clear_key,
  input wire [N_LED-1:0] i_led_src,
  input wire [N_OUT-1:0] i_out_src,
  input wire [N_SCADA-1:0] i_scada_src,
  input wire [N_SG-1:0] i_trip_src,
  output reg [N_LED-1:0] o_led,
  output reg [N_OUT-1:0] o_out,
  output reg [N_SCADA-1:0] o_scada,
  output reg [N_SG-1:0] o_trip,
  output reg o_lamp_red,
  output reg o_lamp_green,
  output reg o_select_open,
  output reg o_pw_request
);
  localparam S_IDLE = 2'h0;
  localparam S_SELECT = 2'h1;
  localparam S_PW = 2'h2;

  reg [7:0] ctrl_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [3:0] pend_r;
  reg [3:0] pend_nxt;
  reg [3:0] sel_r;
  reg [3:0] sel_nxt;
  reg [N_LED-1:0] led_lat_r;
  reg [N_OUT-1:0] out_lat_r;
  reg [N_SCADA-1:0] scada_lat_r;
  reg [N_SG-1:0] trip_lat_r;
  reg [N_OUT-1:0] out_rel_r;
  reg [15:0] off_cnt_r [0:N_OUT-1];
  reg [3:0] ack_nxt;
  reg [N_SG-1:0] sg_ack_nxt;
  wire key_short;
  wire key_long;
  wire lamp_red;
  wire lamp_green;
  wire [2:0] scope = ctrl_r[`LAC_CTRL_SCOPE_LSB+2:`LAC_CTRL_SCOPE_LSB];
  wire remote_en = ctrl_r[`LAC_CTRL_REMOTE_EN];
  wire edit_mode = ctrl_r[`LAC_CTRL_EDIT_MODE];
  wire pw_empty = ctrl_r[`LAC_CTRL_PW_EMPTY];
  wire wr_cmd = i_wr && i_addr == `LAC_ADDR_CMD;
  wire [6:0] cmd = wr_cmd ? i_wdata[6:0] : 7'h00;
  integer k;

  // Category mask from command bits: LED, OUT, SCADA, TRIP
  function [3:0] cmd_mask;
    input [6:0] c;
    begin
      cmd_mask = c[`LAC_CMD_ALL] ? 4'hF :
        {1'b0, c[`LAC_CMD_SCADA], c[`LAC_CMD_OUT], c[`LAC_CMD_LED]};
    end
  endfunction

  // Password required unless LEDs are not touched and level-1 password is empty
  function need_pw;
    input [3:0] m;
    input empty;
    begin
      need_pw = m[0] | ~empty;
    end
  endfunction

  lac_key_timer #(
    .LONG_CYC(LONG_CYC),
    .CW(CW)
  ) u_key (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_key(i_clear_key),
    .i_block(edit_mode),
    .o_short(key_short),
    .o_long(key_long)
  );

  lac_lamp_test #(
    .PHASE_CYC(LAMP_CYC),
    .CW(CW)
  ) u_lamp (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(ack_nxt[0]),
    .o_red(lamp_red),
    .o_green(lamp_green)
  );

  always @*
  begin
    state_nxt = state_r;
    pend_nxt = pend_r;
    sel_nxt = sel_r;
    ack_nxt = 4'h0;
    sg_ack_nxt = {N_SG{1'b0}};
    case (state_r)
      S_IDLE:
      begin
        if (key_long)
        begin
          case (scope)
            `LAC_SCOPE_LEDS_NO_PW: ack_nxt = 4'h1;
            `LAC_SCOPE_LEDS: pend_nxt = 4'h1;
            `LAC_SCOPE_LEDS_AND_OUTPUTS: pend_nxt = 4'h3;
            `LAC_SCOPE_EVERYTHING: pend_nxt = 4'hF;
            default: pend_nxt = 4'h0;
          endcase
          if (pend_nxt != 4'h0)
          begin
            if (need_pw(pend_nxt, pw_empty))
              state_nxt = S_PW;
            else
            begin
              ack_nxt = pend_nxt;
              pend_nxt = 4'h0;
            end
          end
        end
        else if (key_short)
        begin
          sel_nxt = 4'h0;
          state_nxt = S_SELECT;
        end
        else if (remote_en && cmd_mask(cmd) != 4'h0)
        begin
          pend_nxt = cmd_mask(cmd);
          if (need_pw(pend_nxt, pw_empty))
            state_nxt = S_PW;
          else
          begin
            ack_nxt = pend_nxt;
            pend_nxt = 4'h0;
          end
        end
      end
      S_SELECT:
      begin
        sel_nxt = sel_r | cmd_mask(cmd);
        if (cmd[`LAC_CMD_CONFIRM])
        begin
          if (sel_nxt == 4'h0)
            state_nxt = S_IDLE;
          else if (need_pw(sel_nxt, pw_empty))
          begin
            pend_nxt = sel_nxt;
            state_nxt = S_PW;
          end
          else
          begin
            ack_nxt = sel_nxt;
            state_nxt = S_IDLE;
          end
        end
        else if (cmd[`LAC_CMD_CANCEL])
          state_nxt = S_IDLE;
      end
      S_PW:
      begin
        if (cmd[`LAC_CMD_PW_OK])
        begin
          ack_nxt = pend_r;
          pend_nxt = 4'h0;
          state_nxt = S_IDLE;
        end
        else if (cmd[`LAC_CMD_CANCEL])
        begin
          pend_nxt = 4'h0;
          state_nxt = S_IDLE;
        end
      end
      default:
        state_nxt = S_IDLE;
    endcase
    if (remote_en && i_wr && i_addr == `LAC_ADDR_SG_ACK)
      sg_ack_nxt = i_wdata[N_SG-1:0];
  end

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_r <= `LAC_CTRL_RST;
      state_r <= S_IDLE;
      pend_r <= 4'h0;
      sel_r <= 4'h0;
      led_lat_r <= {N_LED{1'b0}};
      out_lat_r <= {N_OUT{1'b0}};
      scada_lat_r <= {N_SCADA{1'b0}};
      trip_lat_r <= {N_SG{1'b0}};
      out_rel_r <= {N_OUT{1'b0}};
      for (k = 0; k < N_OUT; k = k + 1)
        off_cnt_r[k] <= 16'h0000;
    end
    else
    begin
      if (i_wr && i_addr == `LAC_ADDR_CTRL)
        ctrl_r <= i_wdata[7:0];
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      sel_r <= sel_nxt;
      // clear only inactive sources; set wins
      led_lat_r <= i_led_src | (led_lat_r & ~({N_LED{ack_nxt[0]}}));
      scada_lat_r <= i_scada_src | (scada_lat_r & ~({N_SCADA{ack_nxt[2]}}));
      trip_lat_r <= i_trip_src | (trip_lat_r & ~({N_SG{ack_nxt[3]}} | sg_ack_nxt));
      for (k = 0; k < N_OUT; k = k + 1)
      begin
        if (i_out_src[k])
        begin
          out_lat_r[k] <= 1'b1;
          out_rel_r[k] <= 1'b0;
          off_cnt_r[k] <= 16'h0000;
        end
        else if (ack_nxt[1] && out_lat_r[k])
        begin
          out_rel_r[k] <= 1'b1;
          off_cnt_r[k] <= 16'h0000;
        end
        else if (out_rel_r[k])
        begin
          if (off_cnt_r[k] == OFF_DLY_CYC[15:0] - 16'h0001)
          begin
            out_lat_r[k] <= 1'b0;
            out_rel_r[k] <= 1'b0;
          end
          else
            off_cnt_r[k] <= off_cnt_r[k] + 16'h0001;
        end
      end
    end
  end

  // Registered outputs and read data
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 32'h00000000;
      o_led <= {N_LED{1'b0}};
      o_out <= {N_OUT{1'b0}};
      o_scada <= {N_SCADA{1'b0}};
      o_trip <= {N_SG{1'b0}};
      o_lamp_red <= 1'b0;
      o_lamp_green <= 1'b0;
      o_select_open <= 1'b0;
      o_pw_request <= 1'b0;
    end
    else
    begin
      o_led <= (lamp_red | lamp_green) ? {N_LED{1'b1}} : (led_lat_r | i_led_src);
      o_out <= out_lat_r | i_out_src;
      o_scada <= scada_lat_r | i_scada_src;
      o_trip <= trip_lat_r | i_trip_src;
      o_lamp_red <= lamp_red;
      o_lamp_green <= lamp_green;
      o_select_open <= state_r == S_SELECT;
      o_pw_request <= state_r == S_PW;
      o_rdata <= 32'h00000000;
      if (i_rd)
      begin
        case (i_addr)
          `LAC_ADDR_CTRL: o_rdata <= {24'h000000, ctrl_r};
          `LAC_ADDR_STATUS: o_rdata <= {22'h000000, lamp_green, lamp_red,
            pend_r, state_r, sel_r[1:0]};
          `LAC_ADDR_LED_LAT: o_rdata[N_LED-1:0] <= led_lat_r;
          `LAC_ADDR_OUT_LAT: o_rdata[N_OUT-1:0] <= out_lat_r;
          `LAC_ADDR_SCADA_LAT: o_rdata[N_SCADA-1:0] <= scada_lat_r;
          `LAC_ADDR_TRIP_LAT: o_rdata[N_SG-1:0] <= trip_lat_r;
          default: o_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // lac_ctrl

// ===== dv/lac_ctrl_checker.sv
// Purpose: port checks for lac_ctrl
// Assumes: one clock, async active-low reset
// Notes: lamp lengths checked only to 8 cycles
`timescale 1ns/1ps
module lac_ctrl_checker #(
  parameter N_LED = 14,
  parameter N_OUT = 8,
  parameter N_SCADA = 16,
  parameter N_SG = 4
)(
  input wire i_clk,
  input wire i_rst_n,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire [N_OUT-1:0] i_out_src,
  input wire [N_SCADA-1:0] i_scada_src,
  input wire [N_SG-1:0] i_trip_src,
  input wire [N_LED-1:0] o_led,
  input wire [N_OUT-1:0] o_out,
  input wire [N_SCADA-1:0] o_scada,
  input wire [N_SG-1:0] o_trip,
  input wire o_lamp_red,
  input wire o_lamp_green
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Hold off the set checks until 3 cycles after reset
  reg [1:0] up_r;
  always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      up_r <= 2'h0;
    else if (up_r != 2'h3)
      up_r <= up_r + 2'h1;
  AST_RED_TO_GREEN: assert property ($fell(o_lamp_red) |-> o_lamp_green)
    else $error("green phase did not follow red");
  AST_LAMP_EXCL: assert property (!(o_lamp_red && o_lamp_green))
    else $error("both lamp phases on");
  AST_LAMP_LEDS: assert property ((o_lamp_red || o_lamp_green) |-> &o_led)
    else $error("LEDs not all lit in lamp test");
  AST_RED_LEN: assert property ($rose(o_lamp_red) |-> o_lamp_red [*8])
    else $error("red phase too short");
  AST_GREEN_LEN: assert property ($rose(o_lamp_green) |-> (o_lamp_green || o_lamp_red) [*8])
    else $error("green phase too short");
  AST_SCADA_SET: assert property (up_r == 2'h3 |=>
    (o_scada & $past(i_scada_src, 2)) == $past(i_scada_src, 2))
    else $error("active SCADA source not shown");
  AST_TRIP_SET: assert property (up_r == 2'h3 |=>
    (o_trip & $past(i_trip_src, 2)) == $past(i_trip_src, 2))
    else $error("active trip source not shown");
  AST_OUT_KEEP: assert property (up_r == 2'h3 |=>
    (o_out & $past(i_out_src, 2)) == $past(i_out_src, 2))
    else $error("output latch not held after source");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule // lac_ctrl_checker
bind lac_ctrl lac_ctrl_checker #(.N_LED(N_LED), .N_OUT(N_OUT), .N_SCADA(N_SCADA), .N_SG(N_SG))
  u_lac_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_out_src(i_out_src), .i_scada_src(i_scada_src), .i_trip_src(i_trip_src),
  .o_led(o_led), .o_out(o_out), .o_scada(o_scada), .o_trip(o_trip),
  .o_lamp_red(o_lamp_red), .o_lamp_green(o_lamp_green));

// ===== dv/lac_keypad.sv
// Purpose: panel clear key model
// Assumes: key already debounced
// Notes: press length in clock cycles
`timescale 1ns/1ps
module lac_keypad (
  input wire i_clk,
  output reg o_key
);
  initial o_key = 1'b0;
  task automatic press(input int n);
    @(posedge i_clk);
    o_key <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_key <= 1'b0;
    @(posedge i_clk);
  endtask
endmodule // lac_keypad

// ===== dv/tb_top.sv
// Purpose: self-checking bench for lac_ctrl
// Assumes: short counts of 20 cycles, 10-cycle off delay
// Notes: latch state read back over the register port
`timescale 1ns/1ps
module tb_top;
  localparam int OFF = 10;
  logic i_clk, i_rst_n, i_wr, i_rd, key;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [41:0] src;
  logic [13:0] o_led;
  logic [7:0] o_out;
  logic [15:0] o_scada;
  logic [3:0] o_trip;
  logic o_lamp_red, o_lamp_green, o_select_open, o_pw_request;
  int mismatches, tests_run, cycles;
  // Command nibble, cleared categories
  logic [7:0] rows [4] = '{8'h11, 8'h22, 8'h44, 8'h8F};
  // Scope code, cleared categories
  logic [7:0] sc [4] = '{8'h00, 8'h21, 8'h33, 8'h4F};
  lac_ctrl #(.LONG_CYC(20), .LAMP_CYC(20), .OFF_DLY_CYC(OFF)) i_lac_ctrl (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_clear_key(key),
    .i_led_src(src[13:0]), .i_out_src(src[21:14]), .i_scada_src(src[37:22]),
    .i_trip_src(src[41:38]), .o_led(o_led), .o_out(o_out), .o_scada(o_scada),
    .o_trip(o_trip), .o_lamp_red(o_lamp_red), .o_lamp_green(o_lamp_green),
    .o_select_open(o_select_open), .o_pw_request(o_pw_request));
  lac_keypad i_lac_keypad (.i_clk(i_clk), .o_key(key));
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, run needs about 1050 cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask
  // Pulse the sources in pattern p for one cycle
  task automatic fill_pat(input logic [41:0] p);
    @(posedge i_clk);
    src <= p;
    @(posedge i_clk);
    src <= '0;
    cyc(2);
  endtask
  // Every latch set
  task automatic fill;
    fill_pat('1);
  endtask
  task automatic lat(input logic [3:0] c);
    rd(4, c[0] ? 32'h0 : 32'h3FFF);
    rd(5, c[1] ? 32'h0 : 32'hFF);
    rd(6, c[2] ? 32'h0 : 32'hFFFF);
    rd(7, c[3] ? 32'h0 : 32'hF);
  endtask
  // Password only when LEDs are in the mask
  task automatic ack(input logic [3:0] c, input logic pw);
    wr(1, {28'h0, c});
    cyc(3);
    chk(o_pw_request, pw);
    if (pw)
    begin
      rd(2, {24'h0, c[3] ? 4'hF : c, 4'h8});
      wr(1, 32'h20);
    end
    cyc(OFF + 5);
  endtask
  initial
  begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    src = '0;
    cyc(4);
    i_rst_n <= 1'b1;
    rd(0, 32'h9);
    fill;
    i_lac_keypad.press(30);
    chk(o_lamp_red, 1'b1);
    chk(o_pw_request, 1'b0);
    cyc(OFF + 2);
    chk(o_lamp_green, 1'b1);
    lat(4'h1);
    cyc(40);
    wr(0, 32'h29);
    for (int i = 0; i < 4; i++)
    begin
      fill;
      ack(rows[i][7:4], rows[i][0]);
      lat(rows[i][3:0]);
      cyc(40);
    end
    fill;
    wr(3, 32'h4);
    cyc(3);
    rd(7, 32'hB);
    wr(1, 32'h2);
    cyc(2);
    rd(5, 32'hFF);
    cyc(OFF);
    rd(5, 32'h0);
    @(posedge i_clk);
    src[22] <= 1'b1;
    ack(4'h8, 1'b1);
    rd(6, 32'h1);
    src <= '0;
    cyc(40);
    fill;
    wr(0, 32'h21);
    wr(1, 32'h4);
    cyc(3);
    rd(6, 32'hFFFF);
    wr(0, 32'h29);
    i_lac_keypad.press(5);
    cyc(3);
    chk(o_select_open, 1'b1);
    wr(1, 32'h4);
    cyc(3);
    rd(6, 32'hFFFF);
    wr(1, 32'h10);
    cyc(3);
    rd(6, 32'h0);
    fill;
    wr(0, 32'h39);
    i_lac_keypad.press(30);
    cyc(2);
    chk(o_select_open, 1'b0);
    rd(4, 32'h3FFF);
    wr(1, 32'h4);
    cyc(3);
    rd(6, 32'h0);
    foreach (sc[i])
    begin
      fill;
      wr(0, {28'h0, sc[i][7:4]} | 32'h28);
      i_lac_keypad.press(30);
      cyc(2);
      chk(o_pw_request, sc[i][0]);
      if (sc[i][0])
        wr(1, 32'h20);
      cyc(OFF + 5);
      lat(sc[i][3:0]);
      cyc(40);
    end
    rd(4'hF, 32'h0);
    // Distinct bits per source group
    fill_pat({4'h5, 16'hA5C3, 8'h96, 14'h1234});
    chk(o_led, 32'h1234);
    chk(o_out, 32'h96);
    chk(o_scada, 32'hA5C3);
    chk(o_trip, 32'h5);
    i_lac_keypad.press(30);
    cyc(2);
    chk(o_pw_request, 1'b1);
    wr(1, 32'h40);
    cyc(3);
    chk(o_pw_request, 1'b0);
    rd(6, 32'hA5C3);
    // Reset in mid-run restores scope
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    cyc(2);
    i_rst_n <= 1'b1;
    rd(0, 32'h9);
    final_report;
  end
endmodule // tb_top
